// [bridge_axi_write_ingress.sv]
`timescale 1ns/1ps
`include "wr_ingress_params.svh"
// write address and data ingress of the bridge, system clock domain
module bridge_axi_write_ingress
	import wr_ingress_pkg::*;
#(
	parameter int id_width_param = `ID_W_DEF,
	parameter int USER_W = `USER_W_DEF,
	parameter int DATA_W = `DATA_W_DEF
)
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// write address channel
	input wire logic [id_width_param-1:0] i_awid,
	input wire logic [`ADDR_W-1:0] i_awaddr,
	input wire logic [`LEN_W-1:0] i_awlen,
	input wire logic [`SIZE_W-1:0] i_awsize,
	input wire logic [`BURST_W-1:0] i_awburst,
	input wire logic i_awvalid,
	output logic o_awready,
	// write data channel
	input wire logic [USER_W-1:0] i_wuser,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic [DATA_W/8-1:0] i_wstrb,
	input wire logic i_wlast,
	input wire logic i_wvalid,
	output logic o_wready,
	// beat output toward the link side
	output logic o_beat_valid,
	input wire logic i_beat_ready,
	output logic [`ADDR_W-1:0] o_beat_addr,
	output logic [DATA_W-1:0] o_beat_data,
	output logic [DATA_W/8-1:0] o_beat_strb,
	output logic [USER_W-1:0] o_beat_user,
	output logic o_beat_last,
	output logic [id_width_param-1:0] o_beat_id,
	// burst done, id of the response to be returned
	output logic o_done,
	output logic [id_width_param-1:0] o_done_id,
	// master ended the burst at the wrong beat
	output logic o_last_err
);
	// elaboration-time width
	if (id_width_param < 1 || id_width_param > `ID_W_MAX)
	begin : g_bad_id
		initial $error("id width out of range");
	end
	if (USER_W < 1 || USER_W > `USER_W_MAX)
	begin : g_bad_user
		initial $error("user width out of range");
	end
	if (DATA_W != 32 && DATA_W != 64)
	begin : g_bad_data
		initial $error("data width must be 32 or 64");
	end

	wr_state_t state_r; // control state
	logic [id_width_param-1:0] id_r; // captured transaction id
	logic [`ADDR_W-1:0] addr_r; // current beat address
	logic [`LEN_W-1:0] len_r; // captured length
	logic [`SIZE_W-1:0] size_r; // captured size
	logic [`BURST_W-1:0] burst_r; // captured burst type
	logic [`LEN_W-1:0] left_r; // beats remaining minus one
	logic [`ADDR_W-1:0] addr_nxt; // next beat address
	logic [DATA_W-1:0] merged; // strobed data
	logic aw_fire; // address handshake
	logic w_fire; // data handshake
	logic b_fire; // beat output handshake
	logic beat_last; // this beat closes the burst

	// address accepted only while idle
	assign o_awready = (state_r == ST_IDLE);
	// data accepted only when output slot is free
	assign o_wready = (state_r == ST_DATA) && (!o_beat_valid || i_beat_ready);
	// transfers only on valid and ready together
	assign aw_fire = i_awvalid && o_awready;
	assign w_fire = i_wvalid && o_wready;
	assign b_fire = o_beat_valid && i_beat_ready;
	// length fixes beat count
	assign beat_last = (left_r == 8'h00);

	beat_addr_gen u_addr
	(
		.i_addr(addr_r),
		.i_len(len_r),
		.i_size(size_r),
		.i_burst(burst_r),
		.o_next(addr_nxt)
	);

	// lanes without strobe stay zero toward the link
	lane_merge #(.DATA_W(DATA_W)) u_merge
	(
		.i_old({DATA_W{1'b0}}),
		.i_new(i_wdata),
		.i_strb(i_wstrb),
		.o_data(merged)
	);

	// control state, async low reset, all on system clock
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			state_r <= ST_IDLE;
		else
		begin
			case (state_r)
				// wait for an address
				ST_IDLE:
					if (aw_fire)
						state_r <= ST_DATA;
				// collect the fixed number of beats
				ST_DATA:
					if (w_fire && beat_last)
						state_r <= ST_RESP;
				// drain last beat, then report
				ST_RESP:
					if (!o_beat_valid || i_beat_ready)
						state_r <= ST_IDLE;
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// capture address controls on handshake
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			id_r <= '0;
			len_r <= 8'h00;
			size_r <= 2'h0;
			burst_r <= `BURST_INCR;
		end
		else if (aw_fire)
		begin
			id_r <= i_awid;
			len_r <= i_awlen;
			size_r <= i_awsize;
			burst_r <= i_awburst;
		end
	end

	// beat address and remaining count
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			addr_r <= 32'h00000000;
			left_r <= 8'h00;
		end
		else if (aw_fire)
		begin
			addr_r <= i_awaddr;
			left_r <= i_awlen;
		end
		else if (w_fire)
		begin
			addr_r <= addr_nxt;
			left_r <= left_r - 8'h01;
		end
	end

	// output beat register, the hand-off to link-side logic that runs outside this block
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_beat_valid <= 1'b0;
			o_beat_addr <= 32'h00000000;
			o_beat_data <= '0;
			o_beat_strb <= '0;
			o_beat_user <= '0;
			o_beat_last <= 1'b0;
			o_beat_id <= '0;
		end
		else if (w_fire)
		begin
			// sideband travels with its beat
			o_beat_valid <= 1'b1;
			o_beat_addr <= addr_r;
			o_beat_data <= merged;
			o_beat_strb <= i_wstrb;
			o_beat_user <= i_wuser;
			o_beat_last <= beat_last;
			o_beat_id <= id_r;
		end
		else if (b_fire)
			o_beat_valid <= 1'b0;
	end

	// completion pulse with the burst id
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_done <= 1'b0;
			o_done_id <= '0;
		end
		else
		begin
			o_done <= (state_r == ST_RESP) && (!o_beat_valid || i_beat_ready);
			o_done_id <= id_r;
		end
	end

	// sticky flag: master last disagrees with counted length
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_last_err <= 1'b0;
		else if (w_fire && (i_wlast != beat_last))
			o_last_err <= 1'b1;
	end

	// assertions
	property p_aw_only_idle;
		@(posedge i_clk) disable iff (!i_nrst)
		o_awready |-> state_r == ST_IDLE && !o_wready;
	endproperty
	a_aw_only_idle: assert property (p_aw_only_idle) else $error("awready outside idle");

	property p_aw_to_data;
		@(posedge i_clk) disable iff (!i_nrst)
		aw_fire |=> state_r == ST_DATA && left_r == $past(i_awlen);
	endproperty
	a_aw_to_data: assert property (p_aw_to_data) else $error("length not captured");

	property p_wready_room;
		@(posedge i_clk) disable iff (!i_nrst)
		o_wready |-> (!o_beat_valid || i_beat_ready);
	endproperty
	a_wready_room: assert property (p_wready_room) else $error("wready without room");

	property p_beat_id;
		@(posedge i_clk) disable iff (!i_nrst)
		w_fire |=> o_beat_valid && o_beat_id == $past(id_r) && o_beat_strb == $past(i_wstrb);
	endproperty
	a_beat_id: assert property (p_beat_id) else $error("beat id or strobe wrong");

	property p_done_id;
		@(posedge i_clk) disable iff (!i_nrst)
		o_done |-> o_done_id == id_r;
	endproperty
	a_done_id: assert property (p_done_id) else $error("response id mismatch");

	property p_held;
		@(posedge i_clk) disable iff (!i_nrst)
		o_beat_valid && !i_beat_ready |=> o_beat_valid && $stable(o_beat_data);
	endproperty
	a_held: assert property (p_held) else $error("beat dropped under stall");

	property p_incr_addr;
		@(posedge i_clk) disable iff (!i_nrst)
		w_fire && burst_r == `BURST_INCR |=> addr_r == $past(addr_r) + (32'h00000001 << size_r);
	endproperty
	a_incr_addr: assert property (p_incr_addr) else $error("incr address wrong");

	property p_fixed_addr;
		@(posedge i_clk) disable iff (!i_nrst)
		w_fire && burst_r == `BURST_FIXED |=> $stable(addr_r);
	endproperty
	a_fixed_addr: assert property (p_fixed_addr) else $error("fixed address moved");

	property p_last_end;
		@(posedge i_clk) disable iff (!i_nrst)
		w_fire && beat_last |=> state_r == ST_RESP && o_beat_last ##1 !o_wready;
	endproperty
	a_last_end: assert property (p_last_end) else $error("burst did not end");

	// checker helpers: wrap window of the open burst and byte mask of the held beat
	logic [`ADDR_W-1:0] chk_wrap_win; // wrap window minus one
	logic [DATA_W-1:0] chk_lane_mask; // ones on strobed lanes of the held beat
	assign chk_wrap_win = ((32'(len_r) + 32'h00000001) << size_r) - 32'h00000001;
	genvar lane;
	// one mask byte per strobe bit
	generate
		for (lane = 0; lane < DATA_W/8; lane++)
		begin : g_chk_mask
			assign chk_lane_mask[8*lane+7:8*lane] = {8{o_beat_strb[lane]}};
		end
	endgenerate

	property p_wrap_addr;
		@(posedge i_clk) disable iff (!i_nrst)
		w_fire && burst_r == `BURST_WRAP |=> (addr_r & ~chk_wrap_win) == ($past(addr_r) & ~chk_wrap_win);
	endproperty
	a_wrap_addr: assert property (p_wrap_addr) else $error("wrap address left its window");

	property p_count_down;
		@(posedge i_clk) disable iff (!i_nrst)
		w_fire && !beat_last |=> state_r == ST_DATA && left_r == $past(left_r) - 8'h01;
	endproperty
	a_count_down: assert property (p_count_down) else $error("beat count not stepped");

	property p_beat_fields;
		@(posedge i_clk) disable iff (!i_nrst)
		w_fire |=> o_beat_user == $past(i_wuser) && o_beat_addr == $past(addr_r) && o_beat_last == $past(beat_last);
	endproperty
	a_beat_fields: assert property (p_beat_fields) else $error("beat sideband or address wrong");

	property p_lane_data;
		@(posedge i_clk) disable iff (!i_nrst)
		w_fire |=> o_beat_data == ($past(i_wdata) & chk_lane_mask);
	endproperty
	a_lane_data: assert property (p_lane_data) else $error("byte lanes not set by strobes");

	property p_done_idle;
		@(posedge i_clk) disable iff (!i_nrst)
		o_done |-> state_r == ST_IDLE && !o_beat_valid;
	endproperty
	a_done_idle: assert property (p_done_idle) else $error("completion before last beat left");

	property p_err_sticky;
		@(posedge i_clk) disable iff (!i_nrst)
		o_last_err |=> o_last_err;
	endproperty
	a_err_sticky: assert property (p_err_sticky) else $error("last error flag cleared");
endmodule

// [wr_ingress_params.svh]
// Function
// - slave interface runs on system clock
// - common mode runs everything on system clock
// - link-side logic uses link clock only independently
// - active-low reset asserts asynchronously
// - id width configurable one to six
// - later beat addresses derived from controls
// - length field fixes exact beat count
// - strobes, not size, select updated lanes
// - burst type plus size gives addresses
// - address ready only when acceptable
// - user sideband one to four bits
// - data width 32 or 64
// - one strobe per data byte
// - data ready only when beat accepted
// - response id equals write address id
`ifndef WR_INGRESS_PARAMS_SVH
`define WR_INGRESS_PARAMS_SVH
`define ID_W_DEF 4
`define ID_W_MAX 6
`define USER_W_DEF 1
`define USER_W_MAX 4
`define DATA_W_DEF 32
`define ADDR_W 32
`define LEN_W 8
`define SIZE_W 2
`define BURST_W 2
`define BURST_FIXED 2'h0
`define BURST_INCR 2'h1
`define BURST_WRAP 2'h2
`define WRAP_BOUND_LO_LEN 8'h01
`endif

// [wr_ingress_pkg.sv]
package wr_ingress_pkg;
	// write ingress control states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_DATA,
		ST_RESP
	} wr_state_t;
endpackage

// [beat_addr_gen.sv]
`timescale 1ns/1ps
`include "wr_ingress_params.svh"
// next beat address from burst type, size and length
module beat_addr_gen
(
	// burst controls
	input wire logic [`ADDR_W-1:0] i_addr,
	input wire logic [`LEN_W-1:0] i_len,
	input wire logic [`SIZE_W-1:0] i_size,
	input wire logic [`BURST_W-1:0] i_burst,
	// result
	output logic [`ADDR_W-1:0] o_next
);
	logic [`ADDR_W-1:0] step; // bytes per beat
	logic [`ADDR_W-1:0] wmask; // wrap window minus one
	logic [`ADDR_W-1:0] inc; // plain increment
	always_comb
	begin
		step = 32'h00000001 << i_size;
		wmask = (({24'h000000, i_len} + 32'h00000001) << i_size) - 32'h00000001;
		inc = i_addr + step;
		// burst type and size pick the next address
		case (i_burst)
			`BURST_FIXED: o_next = i_addr;
			`BURST_WRAP: o_next = (i_addr & ~wmask) | (inc & wmask);
			default: o_next = inc;
		endcase
	end
endmodule

// [lane_merge.sv]
`timescale 1ns/1ps
`include "wr_ingress_params.svh"
// applies write strobes per byte lane onto held data
module lane_merge #(
	parameter int DATA_W = `DATA_W_DEF
)
(
	// inputs
	input wire logic [DATA_W-1:0] i_old,
	input wire logic [DATA_W-1:0] i_new,
	input wire logic [DATA_W/8-1:0] i_strb,
	// merged
	output logic [DATA_W-1:0] o_data
);
	genvar n;
	generate
		for (n = 0; n < DATA_W/8; n++)
		begin : g_lane
			// strobe n qualifies bits 8n+7..8n
			assign o_data[8*n+7:8*n] = i_strb[n] ? i_new[8*n+7:8*n] : i_old[8*n+7:8*n];
		end
	endgenerate
endmodule

// [axi_wr_master.sv]
`timescale 1ns/1ps
// local write master: one burst at a time, optional idle cycles between beats
module axi_wr_master
(
	// clock
	input wire logic i_clk,
	// address channel
	output logic [3:0] o_awid,
	output logic [31:0] o_awaddr,
	output logic [7:0] o_awlen,
	output logic [1:0] o_awsize,
	output logic [1:0] o_awburst,
	output logic o_awvalid,
	input wire logic i_awready,
	// data channel
	output logic [0:0] o_wuser,
	output logic [31:0] o_wdata,
	output logic [3:0] o_wstrb,
	output logic o_wlast,
	output logic o_wvalid,
	input wire logic i_wready
);
	// idle bus at time zero
	initial
	begin
		{o_awid, o_awaddr, o_awlen, o_awsize, o_awburst, o_awvalid} = '0;
		{o_wuser, o_wdata, o_wstrb, o_wlast, o_wvalid} = '0;
	end
	// one burst; bad toggles the last flag on the first beat, which is also the last beat when n is 0
	task automatic burst(input logic [3:0] id, input logic [31:0] a, input logic [7:0] n,
		input logic [1:0] sz, bt, input logic [31:0] d [16], input logic [3:0] s [16],
		input logic [0:0] u [16], input int stall, input int bad);
		int k;
		@(posedge i_clk);
		#1;
		{o_awid, o_awaddr, o_awlen, o_awsize, o_awburst, o_awvalid} = {id, a, n, sz, bt, 1'b1};
		do @(posedge i_clk); while (i_awready !== 1'b1);
		#1;
		o_awvalid = 0;
		o_awaddr = ~o_awaddr; // released lines show no stale value
		for (k = 0; k <= n; k++)
		begin
			// valid drops between beats only when idle cycles are asked for
			if (stall > 0)
			begin
				o_wvalid = 0;
				o_wdata = ~o_wdata;
				repeat (stall) @(posedge i_clk);
				#1;
			end
			{o_wdata, o_wstrb, o_wuser, o_wvalid} = {d[k], s[k], u[k], 1'b1};
			o_wlast = (k == n) != (bad != 0 && k == 0);
			do @(posedge i_clk); while (i_wready !== 1'b1);
			#1;
		end
		o_wvalid = 0;
		o_wdata = ~o_wdata;
		@(posedge i_clk);
	endtask
endmodule

// [tb.sv]
`timescale 1ns/1ps
`include "wr_ingress_params.svh"
// write ingress bench: beats are predicted per burst and checked as they leave
module tb;
	logic i_clk, i_nrst, i_beat_ready, awvalid, awready, wlast, wvalid, wready;
	logic [3:0] awid, wstrb, beat_strb, beat_id, done_id;
	logic [31:0] awaddr, wdata, beat_addr, beat_data;
	logic [7:0] awlen;
	logic [1:0] awsize, awburst;
	logic [0:0] wuser, beat_user;
	logic beat_valid, beat_last, done, last_err;
	logic [73:0] exp_q[$]; // predicted beats
	logic [3:0] id_q[$]; // predicted burst ends
	logic [73:0] got_beat; // leaving beat as one word
	int errors, samples_checked, cyc, t, g;
	// clock of 8 ns; no deskew delay reference is made, the link pins lie outside this block
	initial
	begin
		i_clk = 0;
		forever #4 i_clk = ~i_clk;
	end
	axi_wr_master u_mst (.i_clk(i_clk), .o_awid(awid), .o_awaddr(awaddr), .o_awlen(awlen),
		.o_awsize(awsize), .o_awburst(awburst), .o_awvalid(awvalid), .i_awready(awready),
		.o_wuser(wuser), .o_wdata(wdata), .o_wstrb(wstrb), .o_wlast(wlast), .o_wvalid(wvalid),
		.i_wready(wready));
	bridge_axi_write_ingress #(.id_width_param(4), .USER_W(1), .DATA_W(32)) dut (.i_clk(i_clk),
		.i_nrst(i_nrst), .i_awid(awid), .i_awaddr(awaddr), .i_awlen(awlen), .i_awsize(awsize),
		.i_awburst(awburst), .i_awvalid(awvalid), .o_awready(awready), .i_wuser(wuser),
		.i_wdata(wdata), .i_wstrb(wstrb), .i_wlast(wlast), .i_wvalid(wvalid), .o_wready(wready),
		.o_beat_valid(beat_valid), .i_beat_ready(i_beat_ready), .o_beat_addr(beat_addr),
		.o_beat_data(beat_data), .o_beat_strb(beat_strb), .o_beat_user(beat_user),
		.o_beat_last(beat_last), .o_beat_id(beat_id), .o_done(done), .o_done_id(done_id),
		.o_last_err(last_err));
	assign got_beat = {beat_addr, beat_data, beat_strb, beat_user, beat_last, beat_id};
	// compare and count
	task automatic cmp(input logic [73:0] got, exp);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// verdict
	task end_sim;
		$display("checks=%0d errors=%0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// link side stalls at random
	always @(posedge i_clk) #1 i_beat_ready = $urandom_range(3) != 0;
	// watcher at mid-cycle, where outputs are settled: a beat taken at the next edge and each burst end
	// take the oldest note
	always @(negedge i_clk)
	begin
		if (i_nrst === 1'b1 && beat_valid === 1'b1)
		begin
			cmp(awready, 1'b0);
			if (i_beat_ready === 1'b1) cmp(got_beat, exp_q.pop_front());
		end
		if (i_nrst === 1'b1 && done === 1'b1) cmp(done_id, id_q.pop_front());
	end
	// hang guard
	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			end_sim;
		end
	end
	// one predicted burst of the given type
	task automatic run(input logic [1:0] bt, input int stall, input int bad);
		logic [31:0] d [16];
		logic [3:0] s [16];
		logic [0:0] u [16];
		logic [31:0] a0, a, base, win, m;
		logic [7:0] n;
		logic [1:0] sz;
		logic [3:0] id;
		int k, j;
		sz = 2'($urandom_range(2));
		id = 4'($urandom);
		n = (bt == `BURST_WRAP) ? (8'h01 << $urandom_range(3)) - 8'h01 : 8'($urandom_range(15));
		a0 = $urandom & ~((32'h1 << sz) - 32'h1);
		win = 32'(n + 1) << sz;
		base = a0 & ~(win - 32'h1);
		for (k = 0; k <= n; k++)
		begin
			{d[k], s[k], u[k]} = {$urandom, 4'($urandom), 1'($urandom)};
			a = (bt == `BURST_FIXED) ? a0 : (bt == `BURST_WRAP) ? base + ((a0 - base + (k << sz)) % win)
				: a0 + (k << sz);
			for (j = 0; j < 4; j++) m[8*j+:8] = {8{s[k][j]}};
			exp_q.push_back({a, d[k] & m, s[k], u[k], k == n, id});
		end
		id_q.push_back(id);
		u_mst.burst(id, a0, n, sz, bt, d, s, u, stall, bad);
		while (id_q.size() != 0) @(posedge i_clk);
	endtask
	// main sequence
	initial
	begin
		i_nrst = 0;
		t = $urandom(50083);
		repeat (2) @(posedge i_clk);
		#1 i_nrst = 1;
		cmp({awready, wready}, 2'b10);
		for (t = 0; t < 4; t++) for (g = 0; g < 3; g++) run(t[1:0], g, 0);
		$display("test burst types done");
		run(`BURST_INCR, 1, 1);
		cmp(last_err, 1'b1);
		$display("test wrong last done");
		#1 i_nrst = 0;
		#1 cmp({last_err, beat_valid, awready, wready}, 4'b0010);
		@(posedge i_clk);
		#1 i_nrst = 1;
		run(`BURST_INCR, 0, 0);
		$display("test async reset done");
		end_sim;
	end
endmodule
